// ==== hdl/bsc_pkg.sv ====
// package: opcodes, widths and constants for the branch/skip/compare decoder
package bsc_pkg;
    // decoded operation selector presented by the core
    typedef enum logic [3:0]
    {
        BSC_OP_NONE,
        BSC_OP_INDIRECT_CALL,
        BSC_OP_COMPARE_SKIP_EQUAL,
        BSC_OP_COMPARE_IMMEDIATE,
        BSC_OP_SKIP_REG_BIT_CLEAR,
        BSC_OP_SKIP_REG_BIT_SET,
        BSC_OP_SKIP_IO_BIT_CLEAR,
        BSC_OP_SKIP_IO_BIT_SET,
        BSC_OP_BRANCH_FLAG_SET,
        BSC_OP_BRANCH_FLAG_CLEARED
    } bsc_op_e;

    localparam int BSC_PC_W = 16;
    localparam int BSC_OFS_W = 7;
    localparam logic [BSC_PC_W-1:0] BSC_STEP_ONE = 16'h0001;
    localparam logic [BSC_PC_W-1:0] BSC_SKIP_SHORT = 16'h0002;
    localparam logic [BSC_PC_W-1:0] BSC_SKIP_LONG = 16'h0003;
    localparam logic [BSC_PC_W-1:0] BSC_PC_RESET = 16'h0000;
    // status flag positions
    localparam int BSC_FLAG_C = 0;
    localparam int BSC_FLAG_Z = 1;
    localparam int BSC_FLAG_N = 2;
    localparam int BSC_FLAG_V = 3;
    localparam int BSC_FLAG_S = 4;
    localparam int BSC_FLAG_H = 5;
    localparam logic [7:0] BSC_STATUS_REGISTER_RESET = 8'h00;
endpackage : bsc_pkg

// ==== hdl/bsc_decode.sv ====
// branch, skip and compare execute logic of an 8-bit core
`timescale 1ns/1ps
// Function
// - indirect call pushes return, jumps to pointer
// - compare-skip equal skips next, 2 or 3
// - compare immediate sets six flags, no store
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - flag set branches to pc+k+1
// - flag cleared branches to pc+k+1
module bsc_decode
    import bsc_pkg::*;
#(
    parameter int PC_W = BSC_PC_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic exec_valid,
    input wire bsc_op_e exec_op,
    input wire logic [PC_W-1:0] pc_cur,
    input wire logic [PC_W-1:0] pointer_pair,
    input wire logic [7:0] reg_a,
    input wire logic [7:0] reg_b,
    input wire logic [7:0] imm_const,
    input wire logic [7:0] io_value,
    input wire logic [2:0] bit_sel,
    input wire logic [BSC_OFS_W-1:0] branch_ofs,
    input wire logic next_is_long,
    input wire logic [7:0] status_register,
    output logic pc_load_q,
    output logic [PC_W-1:0] pc_next_q,
    output logic push_q,
    output logic [PC_W-1:0] push_addr_q,
    output logic status_register_we_q,
    output logic [7:0] status_register_new_q,
    output logic skip_q,
    output logic taken_q
);
    // skip distance covers the one- or two-word following instruction
    function automatic logic [PC_W-1:0] skip_target(
        input logic [PC_W-1:0] pc,
        input logic long_next
    );
        skip_target = pc + (long_next ? PC_W'(BSC_SKIP_LONG)
                                      : PC_W'(BSC_SKIP_SHORT));
    endfunction : skip_target

    logic skip_d;
    logic br_d;
    logic [PC_W-1:0] br_target;
    logic [PC_W-1:0] ofs_ext;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic [7:0] flags_d;

    // signed offset lets backward loops reach lower addresses
    assign ofs_ext = PC_W'($signed(branch_ofs));
    assign br_target = pc_cur + ofs_ext + PC_W'(BSC_STEP_ONE);

    // skip and branch conditions
    always_comb
    begin
        skip_d = 1'b0;
        br_d = 1'b0;
        case (exec_op)
            BSC_OP_COMPARE_SKIP_EQUAL: skip_d = (reg_a == reg_b);
            BSC_OP_SKIP_REG_BIT_CLEAR: skip_d = ~reg_a[bit_sel];
            BSC_OP_SKIP_REG_BIT_SET: skip_d = reg_a[bit_sel];
            BSC_OP_SKIP_IO_BIT_CLEAR: skip_d = ~io_value[bit_sel];
            BSC_OP_SKIP_IO_BIT_SET: skip_d = io_value[bit_sel];
            BSC_OP_BRANCH_FLAG_SET:
                br_d = status_register[bit_sel];
            BSC_OP_BRANCH_FLAG_CLEARED:
                br_d = ~status_register[bit_sel];
            default:
            begin
                skip_d = 1'b0;
                br_d = 1'b0;
            end
        endcase
    end

    // compare immediate: subtraction result is only used for flags
    assign diff = {1'b0, reg_a} - {1'b0, imm_const};
    assign low_diff = {1'b0, reg_a[3:0]} - {1'b0, imm_const[3:0]};
    always_comb
    begin
        flags_d = status_register;
        flags_d[BSC_FLAG_C] = diff[8];
        flags_d[BSC_FLAG_Z] = (diff[7:0] == 8'h00);
        flags_d[BSC_FLAG_N] = diff[7];
        flags_d[BSC_FLAG_V] = (reg_a[7] ^ imm_const[7]) & (reg_a[7] ^ diff[7]);
        flags_d[BSC_FLAG_S] = diff[7] ^ flags_d[BSC_FLAG_V];
        flags_d[BSC_FLAG_H] = low_diff[4];
    end

    // program counter redirect, one cycle after the execute strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pc_load_q <= 1'b0;
            pc_next_q <= BSC_PC_RESET;
            skip_q <= 1'b0;
            taken_q <= 1'b0;
        end
        else
        begin
            pc_load_q <= 1'b0;
            skip_q <= 1'b0;
            taken_q <= 1'b0;
            if (exec_valid)
            begin
                if (exec_op == BSC_OP_INDIRECT_CALL)
                begin
                    pc_load_q <= 1'b1;
                    pc_next_q <= pointer_pair;
                end
                else if (skip_d)
                begin
                    pc_load_q <= 1'b1;
                    skip_q <= 1'b1;
                    pc_next_q <= skip_target(pc_cur,
                        next_is_long);
                end
                else if (br_d)
                begin
                    pc_load_q <= 1'b1;
                    taken_q <= 1'b1;
                    pc_next_q <= br_target;
                end
            end
        end
    end

    // return address push for the indirect call
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            push_q <= 1'b0;
            push_addr_q <= BSC_PC_RESET;
        end
        else
        begin
            push_q <= exec_valid && (exec_op == BSC_OP_INDIRECT_CALL);
            if (exec_valid && (exec_op == BSC_OP_INDIRECT_CALL))
                push_addr_q <= pc_cur + PC_W'(BSC_STEP_ONE);
        end
    end

    // status write for compare immediate; the register file is untouched
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_register_we_q <= 1'b0;
            status_register_new_q <= BSC_STATUS_REGISTER_RESET;
        end
        else
        begin
            status_register_we_q <= exec_valid && (exec_op == BSC_OP_COMPARE_IMMEDIATE);
            if (exec_valid && (exec_op == BSC_OP_COMPARE_IMMEDIATE))
                status_register_new_q <= flags_d;
        end
    end

    // checks; every pulse is judged one edge after the strobe it answers
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    call_jump_a: assert property (
        exec_valid && exec_op == BSC_OP_INDIRECT_CALL
        |=> pc_load_q && push_q && pc_next_q == $past(pointer_pair))
        else $error("indirect call did not jump and push");
    call_return_a: assert property (
        exec_valid && exec_op == BSC_OP_INDIRECT_CALL
        |=> push_addr_q == $past(pc_cur) + PC_W'(BSC_STEP_ONE))
        else $error("indirect call pushed a wrong return address");
    // the skip length must follow the length of the skipped instruction
    cse_skip_a: assert property (
        exec_valid && exec_op == BSC_OP_COMPARE_SKIP_EQUAL && reg_a == reg_b
        |=> skip_q && pc_load_q
        && pc_next_q == $past(pc_cur) + ($past(next_is_long)
        ? PC_W'(BSC_SKIP_LONG) : PC_W'(BSC_SKIP_SHORT)))
        else $error("compare skip equal did not skip");
    cse_equal_a: assert property (
        exec_valid && exec_op == BSC_OP_COMPARE_SKIP_EQUAL
        |=> skip_q == ($past(reg_a) == $past(reg_b)))
        else $error("compare skip equal skipped on unequal values");
    cpi_flags_a: assert property (
        exec_valid && exec_op == BSC_OP_COMPARE_IMMEDIATE
        && reg_a == imm_const
        |=> status_register_we_q && status_register_new_q[BSC_FLAG_Z] && !status_register_new_q[BSC_FLAG_C])
        else $error("compare immediate flags wrong");
    cpi_borrow_a: assert property (
        exec_valid && exec_op == BSC_OP_COMPARE_IMMEDIATE
        && reg_a < imm_const
        |=> status_register_we_q && status_register_new_q[BSC_FLAG_C] && !status_register_new_q[BSC_FLAG_Z])
        else $error("compare immediate missed a borrow");
    rbc_skip_a: assert property (
        exec_valid && exec_op == BSC_OP_SKIP_REG_BIT_CLEAR
        |=> skip_q == !$past(reg_a[bit_sel]))
        else $error("register bit clear skip wrong");
    rbs_skip_a: assert property (
        exec_valid && exec_op == BSC_OP_SKIP_REG_BIT_SET
        |=> skip_q == $past(reg_a[bit_sel]))
        else $error("register bit set skip wrong");
    iobc_skip_a: assert property (
        exec_valid && exec_op == BSC_OP_SKIP_IO_BIT_CLEAR
        |=> skip_q == !$past(io_value[bit_sel]))
        else $error("io bit clear skip wrong");
    iobs_skip_a: assert property (
        exec_valid && exec_op == BSC_OP_SKIP_IO_BIT_SET
        |=> skip_q == $past(io_value[bit_sel]))
        else $error("io bit set skip wrong");
    // target rebuilt from the inputs, not from the design's own adder
    brs_target_a: assert property (
        exec_valid && exec_op == BSC_OP_BRANCH_FLAG_SET
        && status_register[bit_sel]
        |=> taken_q && pc_load_q && pc_next_q == $past(pc_cur)
        + {{(PC_W-BSC_OFS_W){$past(branch_ofs[BSC_OFS_W-1])}},
        $past(branch_ofs)} + PC_W'(BSC_STEP_ONE))
        else $error("branch on flag set wrong");
    brs_taken_a: assert property (
        exec_valid && exec_op == BSC_OP_BRANCH_FLAG_SET
        |=> taken_q == $past(status_register[bit_sel]))
        else $error("branch on flag set taken wrongly");
    brc_taken_a: assert property (
        exec_valid && exec_op == BSC_OP_BRANCH_FLAG_CLEARED
        |=> taken_q == !$past(status_register[bit_sel]))
        else $error("branch on flag cleared wrong");
    back_branch_a: assert property (
        exec_valid && branch_ofs[BSC_OFS_W-1]
        && exec_op == BSC_OP_BRANCH_FLAG_SET && status_register[bit_sel]
        |=> pc_next_q <= $past(pc_cur))
        else $error("negative offset did not go backward");
    // no strobe, or no operation, must leave the core undisturbed
    idle_quiet_a: assert property (
        !exec_valid || exec_op == BSC_OP_NONE
        |=> !pc_load_q && !push_q && !status_register_we_q && !skip_q && !taken_q)
        else $error("pulse raised without an operation");

    call_c: cover property (exec_valid && exec_op == BSC_OP_INDIRECT_CALL);
    skip_long_c: cover property (skip_d && exec_valid && next_is_long);
    back_c: cover property (exec_valid && br_d && branch_ofs[BSC_OFS_W-1]);
    cpi_c: cover property (exec_valid && exec_op == BSC_OP_COMPARE_IMMEDIATE);
endmodule : bsc_decode

// ==== test/branch_skip_compare_decode_test.sv ====
// self-checking bench for the branch, skip and compare decoder
`timescale 1ns/1ps
module branch_skip_compare_decode_test;
    import bsc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0, lng = 1'b0;
    bsc_op_e op = BSC_OP_NONE;
    logic [15:0] pc = 16'h0000, ptr = 16'h0000, pcn, pa, e;
    logic [7:0] ra = 8'h00, rb = 8'h00, imm = 8'h00, io = 8'h00;
    logic [7:0] sr = 8'h00, sn, r;
    logic [2:0] bs = 3'h0;
    logic [6:0] ofs = 7'h00;
    logic ld, ps, we, sk, tk;
    int errors = 0, check_count = 0, cyc = 0;
    bsc_decode bsc_decode_inst (.clk(clk), .rst(rst), .exec_valid(vld),
        .exec_op(op), .pc_cur(pc), .pointer_pair(ptr), .reg_a(ra),
        .reg_b(rb), .imm_const(imm), .io_value(io), .bit_sel(bs),
        .branch_ofs(ofs), .next_is_long(lng), .status_register(sr),
        .pc_load_q(ld), .pc_next_q(pcn), .push_q(ps), .push_addr_q(pa),
        .status_register_we_q(we), .status_register_new_q(sn), .skip_q(sk), .taken_q(tk));
    always #5 clk = ~clk;
    // a hung run is cut short well beyond the roughly 125 cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            end_sim();
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle strobe; the answer has landed by the following fall
    task run(input bsc_op_e o);
        @(negedge clk);
        op = o;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        op = BSC_OP_NONE;
    endtask : run
    task t_call;
        ptr = 16'h0100;
        pc = 16'h0005;
        run(BSC_OP_INDIRECT_CALL);
        chk(pcn, 16'h0100);
        chk(pa, 16'h0006);
        chk({ld, ps, sk, tk}, 16'h000C);
        // a strobe left low must do nothing
        op = BSC_OP_INDIRECT_CALL;
        @(negedge clk);
        chk({ld, ps, we, sk, tk}, 16'h0000);
        // a strobe with no operation must do nothing either
        run(BSC_OP_NONE);
        chk({ld, ps, we, sk, tk}, 16'h0000);
        $display("call test done");
    endtask : t_call
    task t_compare_skip_equal;
        for (int i = 0; i < 3; i++)
        begin
            ra = 8'h5A;
            rb = (i == 2) ? 8'h5B : 8'h5A;
            lng = i[0];
            pc = 16'h0020;
            run(BSC_OP_COMPARE_SKIP_EQUAL);
            chk(sk, (i != 2));
            chk(ld, (i != 2));
            if (i != 2)
                chk(pcn, lng ? 16'h0023 : 16'h0022);
        end
        $display("compare skip test done");
    endtask : t_compare_skip_equal
    // clear and set forms alternate in the enum, so j[0] is the polarity
    task t_bits;
        for (int j = 0; j < 4; j++)
            for (int b = 0; b < 8; b++)
            begin
                ra = (j < 2) ? 8'hA5 : 8'h00;
                io = (j < 2) ? 8'h00 : 8'hA5;
                bs = b[2:0];
                run(bsc_op_e'(int'(BSC_OP_SKIP_REG_BIT_CLEAR) + j));
                e[0] = (((8'hA5 >> b) % 2) == j[0]);
                chk(sk, e[0]);
                chk(ld, e[0]);
                chk(tk, 16'h0000);
            end
        $display("bit skip test done");
    endtask : t_bits
    // offsets cover -2 and both ends of the signed range
    task t_branch;
        sr = 8'h35;
        pc = 16'h0100;
        for (int j = 0; j < 2; j++)
            for (int s = 0; s < 8; s++)
            begin
                bs = s[2:0];
                ofs = (s % 3 == 0) ? 7'h7E : ((s % 3 == 1) ? 7'h3F : 7'h40);
                run(j ? BSC_OP_BRANCH_FLAG_CLEARED : BSC_OP_BRANCH_FLAG_SET);
                chk(tk, sr[s] != j[0]);
                chk(ld, sr[s] != j[0]);
                e = 16'h0101 + {{9{ofs[6]}}, ofs};
                if (sr[s] != j[0])
                    chk(pcn, e);
            end
        $display("branch test done");
    endtask : t_branch
    // flags worked out from the borrow chain of a minus k
    task t_cpi;
        static logic [15:0] a [4] = '{16'h1010, 16'h0001, 16'h8001, 16'h7FFF};
        sr = 8'hC0;
        for (int i = 0; i < 4; i++)
        begin
            ra = a[i][15:8];
            imm = a[i][7:0];
            r = ra - imm;
            e[0] = (~ra[7] & imm[7]) | (imm[7] & r[7]) | (r[7] & ~ra[7]);
            e[1] = (r == 8'h00);
            e[2] = r[7];
            e[3] = (ra[7] & ~imm[7] & ~r[7]) | (~ra[7] & imm[7] & r[7]);
            e[4] = e[2] ^ e[3];
            e[5] = (~ra[3] & imm[3]) | (imm[3] & r[3]) | (r[3] & ~ra[3]);
            run(BSC_OP_COMPARE_IMMEDIATE);
            chk(we, 16'h0001);
            chk(sn, {8'h00, sr[7:6], e[5:0]});
        end
        $display("compare immediate test done");
    endtask : t_cpi
    task end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk({ld, ps, we, sk, tk}, 16'h0000);
        t_call();
        t_compare_skip_equal();
        t_bits();
        t_branch();
        t_cpi();
        end_sim();
    end
endmodule : branch_skip_compare_decode_test
